// File: rtl/pio_pkg.sv
// package: selection codes, defaults and carrier structs for the connector line select
package pio_pkg;

  // input line function codes
  typedef enum logic {
    PIO_IN_PTT  = 1'b0,
    PIO_IN_NONE = 1'b1
  } pio_in_sel_t;

  // output line function codes
  typedef enum logic [1:0] {
    PIO_OUT_ALARM   = 2'h0,
    PIO_OUT_SQUELCH = 2'h1,
    PIO_OUT_STATUS  = 2'h2,
    PIO_OUT_NONE    = 2'h3
  } pio_out_sel_t;

  // values after reset and after a restore-default request
  localparam pio_in_sel_t  PIO_IN_DEFAULT  = PIO_IN_PTT;
  localparam pio_out_sel_t PIO_OUT_DEFAULT = PIO_OUT_ALARM;

  // synchroniser depth for pin inputs
  localparam int unsigned PIO_SYNC_STAGES = 2;

  // a pair of selections
  typedef struct packed {
    pio_in_sel_t  in_sel;
    pio_out_sel_t out_sel;
  } pio_sel_t;

  // configuration user interface commands
  typedef struct packed {
    logic     load;     // place a pending selection
    logic     dflt;     // place the defaults as pending
    logic     confirm;  // adopt the pending selection
    logic     cancel;   // drop the pending selection
    pio_sel_t sel;
  } pio_cmd_t;

  // connector pin levels seen by the block
  typedef struct packed {
    logic prog_in;
    logic ptt_in;
  } pio_pins_t;

endpackage : pio_pkg

// File: rtl/pio_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module pio_sync
  import pio_pkg::*;
#(
  parameter int unsigned W = 2
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : pio_sync
`default_nettype wire

// File: rtl/pio_line_select.sv
// programmable connector input and output line function select
//
// Operation
// RULE_01: there is one programmable input line and one programmable output line, each with its own selection.
// RULE_02: the input selection is either push-to-talk source or unassigned.
// RULE_03: with push-to-talk chosen, the programmable input or the dedicated push-to-talk input requests push-to-talk.
// RULE_04: with unassigned chosen, the programmable input is ignored by every internal function.
// RULE_05: the input default is push-to-talk and a restore-default request loads it.
// RULE_06: the output selection is alarm, squelch, error status or unassigned.
// RULE_07: with alarm chosen, the output carries the alarm relay control signal.
// RULE_08: with squelch chosen, the output carries the dedicated squelch output signal.
// RULE_09: with status chosen, the open-collector output is active while no internal error is flagged.
// RULE_10: with unassigned chosen, the output is connected to nothing and stays inactive.
// RULE_11: the output default is alarm and a restore-default request loads it.
// RULE_12: a pending selection becomes active only on confirm; cancel discards it and keeps the old one.
// RULE_13: routing follows a confirmed change within one clock and reset loads both defaults.
`timescale 1ns/1ps
`default_nettype none
module pio_line_select
  import pio_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst_b,
  // configuration user interface
  input  wire pio_cmd_t  cmd,
  output var  pio_sel_t  active_sel,
  output var  pio_sel_t  pending_sel,
  output var  logic      pending_valid,
  // connector pins
  input  wire pio_pins_t pins,
  output var  logic      prog_out_o,
  output var  logic      prog_out_oe_b,
  // internal functions
  input  wire logic      alarm_relay,
  input  wire logic      squelch_out,
  input  wire logic      error_flag,
  output var  logic      push_to_talk_request
);

  pio_sel_t  act_q;
  pio_sel_t  act_d;
  pio_sel_t  pend_q;
  pio_sel_t  pend_d;
  logic      pvld_q;
  logic      pvld_d;
  logic      ptt_q;
  logic      ptt_d;
  logic      out_q;
  logic      out_d;
  pio_pins_t pins_s;

  // command decode, one-hot in priority order
  typedef enum logic [4:0] {
    CMD_IDLE    = 5'b00001,
    CMD_LOAD    = 5'b00010,
    CMD_DFLT    = 5'b00100,
    CMD_CONFIRM = 5'b01000,
    CMD_CANCEL  = 5'b10000
  } pio_cmd_kind_t;

  pio_cmd_kind_t kind;

  // pin levels pass two flip-flops before use
  pio_sync #(
    .W (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .async_i (pins),
    .sync_o  (pins_s)
  );

  // default pair
  function automatic pio_sel_t dflt_sel();
    pio_sel_t s;
    s.in_sel  = PIO_IN_DEFAULT;                     // see RULE_05
    s.out_sel = PIO_OUT_DEFAULT;                    // see RULE_11
    return s;
  endfunction : dflt_sel

  // cancel wins over confirm, confirm over default, default over load
  function automatic pio_cmd_kind_t cmd_kind(input pio_cmd_t c);
    pio_cmd_kind_t k;
    k = CMD_IDLE;
    if (c.cancel) begin
      k = CMD_CANCEL;
    end else if (c.confirm) begin
      k = CMD_CONFIRM;
    end else if (c.dflt) begin
      k = CMD_DFLT;
    end else if (c.load) begin
      k = CMD_LOAD;
    end
    return k;
  endfunction : cmd_kind

  // push-to-talk request from the dedicated and programmable inputs
  function automatic logic in_route(
    input pio_in_sel_t s,
    input pio_pins_t   p
  );
    logic r;
    r = p.ptt_in;
    unique case (s)
      PIO_IN_PTT: begin
        r = p.ptt_in | p.prog_in;                   // see RULE_02 see RULE_03
      end
      PIO_IN_NONE: begin
        r = p.ptt_in;                               // see RULE_04
      end
    endcase
    return r;
  endfunction : in_route

  // level to show on the programmable output, high means pulling
  function automatic logic out_route(
    input pio_out_sel_t s,
    input logic         alarm,
    input logic         squelch,
    input logic         err
  );
    logic r;
    r = 1'b0;
    unique case (s)
      PIO_OUT_ALARM: begin
        r = alarm;                                  // see RULE_06 see RULE_07
      end
      PIO_OUT_SQUELCH: begin
        r = squelch;                                // see RULE_08
      end
      PIO_OUT_STATUS: begin
        r = ~err;                                   // see RULE_09
      end
      PIO_OUT_NONE: begin
        r = 1'b0;                                   // see RULE_10
      end
    endcase
    return r;
  endfunction : out_route

  // pending and active selections
  always_comb begin
    act_d  = act_q;
    pend_d = pend_q;
    pvld_d = pvld_q;
    kind   = cmd_kind(cmd);
    unique case (kind)
      CMD_CANCEL: begin
        pend_d = act_q;                             // see RULE_12
        pvld_d = 1'b0;
      end
      CMD_CONFIRM: begin
        if (pvld_q) begin
          act_d = pend_q;                           // see RULE_12
        end
        pvld_d = 1'b0;
      end
      CMD_DFLT: begin
        pend_d = dflt_sel();                        // see RULE_05 see RULE_11
        pvld_d = 1'b1;
      end
      CMD_LOAD: begin
        pend_d = cmd.sel;                           // see RULE_01
        pvld_d = 1'b1;
      end
      CMD_IDLE: begin
        pvld_d = pvld_q;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_q  <= '{in_sel: PIO_IN_DEFAULT, out_sel: PIO_OUT_DEFAULT}; // see RULE_13
      pend_q <= '{in_sel: PIO_IN_DEFAULT, out_sel: PIO_OUT_DEFAULT};
      pvld_q <= 1'b0;
    end else begin
      act_q  <= act_d;
      pend_q <= pend_d;
      pvld_q <= pvld_d;
    end
  end

  // input line routing
  always_comb begin
    ptt_d = in_route(act_q.in_sel, pins_s);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ptt_q <= 1'b0;
    end else begin
      ptt_q <= ptt_d;
    end
  end

  // output line routing, follows the active selection one clock later
  always_comb begin
    out_d = out_route(act_q.out_sel, alarm_relay, squelch_out, error_flag);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;                               // see RULE_13
    end
  end

  // open collector: pulls low while active, enable low while driving
  assign prog_out_o           = 1'b0;
  assign prog_out_oe_b        = ~out_q;
  assign push_to_talk_request = ptt_q;
  // configuration state seen by the user interface
  assign active_sel           = act_q;
  assign pending_sel          = pend_q;
  assign pending_valid        = pvld_q;

endmodule : pio_line_select
`default_nettype wire

// File: verification/pio_line_select_props.sv
// checker: selection and routing properties of the line select
`timescale 1ns/1ps
`default_nettype none
module pio_props
  import pio_pkg::*;
(
  // clock and reset
  input wire logic      clk_sys,
  input wire logic      rst_b,
  // watched ports
  input wire pio_cmd_t  cmd,
  input wire pio_sel_t  active_sel,
  input wire pio_sel_t  pending_sel,
  input wire logic      pending_valid,
  input wire pio_pins_t pins,
  input wire logic      prog_out_oe_b,
  input wire logic      alarm_relay,
  input wire logic      squelch_out,
  input wire logic      error_flag,
  input wire logic      push_to_talk_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence quiet_s;
    !pins.ptt_in && active_sel.in_sel == PIO_IN_NONE;
  endsequence
  sequence prog_talk_s;
    pins.prog_in && active_sel.in_sel == PIO_IN_PTT;
  endsequence
  a_reset_dflt: assert property ($rose(rst_b) |-> active_sel == 3'h0) else $error("reset");
  a_confirm_adopt: assert property (cmd.confirm && !cmd.cancel && pending_valid
    |=> active_sel == $past(pending_sel)) else $error("confirm");
  a_cancel_keep: assert property (cmd.cancel |=> $stable(active_sel) && !pending_valid)
    else $error("cancel");
  a_dflt_pend: assert property (cmd.dflt && !cmd.cancel && !cmd.confirm
    |=> pending_sel == 3'h0 && pending_valid) else $error("default");
  a_alarm_route: assert property (active_sel.out_sel == PIO_OUT_ALARM
    |=> prog_out_oe_b == !$past(alarm_relay)) else $error("alarm");
  a_status_route: assert property (active_sel.out_sel == PIO_OUT_STATUS
    |=> prog_out_oe_b == $past(error_flag)) else $error("status");
  a_squelch_route: assert property (active_sel.out_sel == PIO_OUT_SQUELCH
    |=> prog_out_oe_b == !$past(squelch_out)) else $error("squelch");
  a_none_idle: assert property (active_sel.out_sel == PIO_OUT_NONE |=> prog_out_oe_b)
    else $error("none");
  a_prog_ignored: assert property (quiet_s [*3] |=> !push_to_talk_request)
    else $error("ignore");
  a_prog_talk: assert property (prog_talk_s [*3] |=> push_to_talk_request)
    else $error("talk");
endmodule : pio_props
bind pio_line_select pio_props u_props (.clk_sys, .rst_b, .cmd, .active_sel, .pending_sel,
  .pending_valid, .pins, .prog_out_oe_b, .alarm_relay, .squelch_out, .error_flag,
  .push_to_talk_request);
`default_nettype wire

// File: verification/pio_equip.sv
// partner: external equipment on the connector lines
`timescale 1ns/1ps
`default_nettype none
module pio_equip
  import pio_pkg::*;
(
  // open-collector line
  input  wire logic      oe_b,
  input  wire logic      out_o,
  // keys
  input  wire logic      talk_key,
  input  wire logic      aux_key,
  // levels
  output var  pio_pins_t pins,
  output var  logic      line_low
);
  assign pins = {aux_key, talk_key};
  // pull-up holds the line high unless pulled
  assign line_low = !oe_b && !out_o;
endmodule : pio_equip
`default_nettype wire

// File: verification/tb_top.sv
// bench: drives the line select and judges routing and commands
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pio_pkg::*;
;
  logic      clk_sys, rst_b, alarm, squel, err, talk_k, aux_k, oe_b, out_o, talk_r, pv, low;
  pio_cmd_t  cmd;
  pio_sel_t  act, pend;
  pio_pins_t pins;
  int        bad_count = 0;
  int        tests_run = 0;
  pio_line_select dut (.clk_sys, .rst_b, .cmd, .active_sel(act), .pending_sel(pend),
    .pending_valid(pv), .pins, .prog_out_o(out_o), .prog_out_oe_b(oe_b), .alarm_relay(alarm),
    .squelch_out(squel), .error_flag(err), .push_to_talk_request(talk_r));
  pio_equip eq (.oe_b, .out_o, .talk_key(talk_k), .aux_key(aux_k), .pins, .line_low(low));
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task chk(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %b want %b", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task go(input logic [3:0] f, input pio_sel_t s);
    @(posedge clk_sys) cmd <= {f, s};
    @(posedge clk_sys) cmd <= '0;
    cyc(1);
  endtask : go
  task t_route;
    logic [3:0] e;
    for (int c = 0; c < 4; c++) begin
      go(4'h8, {1'b0, c[1:0]});
      go(4'h2, {1'b0, c[1:0]});
      chk(act, {1'b0, c[1:0]});
      for (int v = 0; v < 2; v++) begin
        @(posedge clk_sys) {alarm, squel, err} <= {v[0], !v[0], v[0]};
        cyc(2);
        e = {1'b0, !v[0], !v[0], v[0]};
        chk(low, e[c]);
      end
    end
  endtask : t_route
  task t_cancel;
    go(4'h8, 3'h7);
    go(4'h1, 3'h7);
    chk({pv, act[1:0]}, 3'h3);
    chk(pend, 3'h3);
    go(4'h2, 3'h7);
    chk(act, 3'h3);
    go(4'h4, 3'h7);
    chk(act, 3'h3);
    go(4'h2, 3'h7);
    chk(act, 3'h0);
  endtask : t_cancel
  task t_talk;
    for (int k = 0; k < 4; k++) begin
      go(4'h8, {k[1], 2'h3});
      go(4'h2, {k[1], 2'h3});
      @(posedge clk_sys) {talk_k, aux_k} <= {k[0], !k[0]};
      cyc(4);
      chk(talk_r, k[0] | !k[1]);
      @(posedge clk_sys) {talk_k, aux_k} <= 2'h0;
    end
  endtask : t_talk
  task end_of_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    rst_b = 0;
    cmd = '0;
    {alarm, squel, err, talk_k, aux_k} = 5'h00;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1;
    cyc(2);
    chk({pv, act[1:0]}, 3'h0);
    chk(pend, 3'h0);
    chk({oe_b, talk_r, out_o}, 3'h4);
    t_route;
    t_cancel;
    t_talk;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
